// *** timing_ref_params.svh ***
`ifndef TIMING_REF_PARAMS_SVH
`define TIMING_REF_PARAMS_SVH

// candidate source codes (4 bits)
`define SRC_NONE 4'h0
`define SRC_SUPPLY1 4'h1
`define SRC_SUPPLY2 4'h2
`define SRC_INTERNAL 4'h3
`define SRC_LINE0 4'h4
`define NUM_LINES 6
`define NUM_SRC 10

// ranks: lower is better, 4 bits
`define Q_PRS 4'h1
`define Q_STU 4'h2
`define Q_ST2 4'h3
`define G1_ST3 4'h4
`define G1_SMC 4'h5
`define G1_ST4 4'h6
`define G1_DUS 4'h7
`define G2_TNC 4'h4
`define G2_ST3E 4'h5
`define G2_ST3 4'h6
`define G2_SMC 4'h7
`define G2_ST4 4'h8
`define G2_DUS 4'h9

// s1 low nibble codes
`define S1_PRS 4'h1
`define S1_STU 4'h0
`define S1_ST2 4'h7
`define S1_TNC 4'h4
`define S1_ST3E 4'hd
`define S1_ST3 4'ha
`define S1_SMC 4'hc
`define S1_ST4 4'h8
`define S1_DUS 4'hf
`define S1_RES 4'he

// revert wait unit and rate
`define REVERT_UNIT_NS 1000000
`define CLK_PERIOD_NS 25
`define REVERT_UNIT_CYCLES (`REVERT_UNIT_NS / `CLK_PERIOD_NS)

`endif

// *** timing_ref_pkg.sv ***
`default_nettype none
package timing_ref_pkg;
    typedef enum logic [1:0] {
        MODE_EXTERNAL,
        MODE_LINE,
        MODE_MIXED
    } timing_mode_e;
    typedef logic [3:0] quality_t;
    typedef logic [3:0] source_t;
endpackage
`default_nettype wire

// *** link_edge_detect.sv ***
`timescale 1ns/100ps
`default_nettype none
// samples a link clock and framing health on ref_clk, flags silence
module link_edge_detect #(
    parameter int TIMEOUT = 64
) (
    input wire logic refClk,
    input wire logic rstn,
    input wire logic linkClk,
    input wire logic linkOk,
    output logic linkGood
);
    logic [2:0] clkSync;
    logic [1:0] okSync;
    logic [$clog2(TIMEOUT+1)-1:0] idle;
    wire riseSeen = clkSync[1] & ~clkSync[2];
    wire timedOut = (idle == TIMEOUT[$clog2(TIMEOUT+1)-1:0]);

    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            clkSync <= 3'h0;
            okSync <= 2'h0;
        end else begin
            clkSync <= {clkSync[1:0], linkClk};
            okSync <= {okSync[0], linkOk};
        end
    end

    // a stalled link clock is a loss of signal
    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            idle <= '0;
        end else if (riseSeen) begin
            idle <= '0;
        end else if (!timedOut) begin
            idle <= idle + 1'b1;
        end
    end

    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            linkGood <= 1'b0;
        end else begin
            linkGood <= okSync[1] & ~timedOut;
        end
    end
endmodule // link_edge_detect
`default_nettype wire

// *** timing_reference_selector.sv ***
// Operation
// - three prioritized node references, fail over
// - isolated node falls back to internal oscillator
// - timing mode limits eligible references
// - first-generation quality ranking one to seven
// - second-generation quality ranking one to nine
// - reserved message uses provisioned quality
// - quality from S1 byte avoids loops
// - first-generation maps newer codes down
// - revert to primary after wait time
// - only in-service supply facility gives timing
// - selectable line code per supply facility
// - superframe framing disables status messaging
// - per-facility messaging enable
// - send alarm signal at or below floor when messaging is off
// - six prioritized references for supply outputs
// - supply output enabled when in service
`timescale 1ns/100ps
`default_nettype none
`include "timing_ref_params.svh"
module timing_reference_selector #(
    parameter int LINK_TIMEOUT = 64,
    parameter int REVERT_UNIT = `REVERT_UNIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire timing_ref_pkg::timing_mode_e timingMode,
    input wire logic gen2Set,
    input wire timing_ref_pkg::quality_t reservedQualitySetting,
    input wire logic revertiveEn,
    input wire logic [7:0] revertWaitUnits,
    input wire logic [1:0] supplyInService,
    input wire logic [1:0] supplyB8zs,
    input wire logic [1:0] supplyEsf,
    input wire logic [1:0] supplySsmEn,
    input wire timing_ref_pkg::quality_t alarmSignalQualityFloor,
    input wire timing_ref_pkg::source_t nodeRef1,
    input wire timing_ref_pkg::source_t nodeRef2,
    input wire timing_ref_pkg::source_t nodeRef3,
    input wire logic [23:0] outRefList,
    input wire logic [1:0] supplyClk,
    input wire logic [1:0] supplyFramed,
    input wire logic [7:0] supplySsm,
    input wire logic [5:0] lineClk,
    input wire logic [5:0] lineFramed,
    input wire logic [5:0] lineWorking,
    input wire logic [23:0] lineS1,
    output timing_ref_pkg::source_t nodeSource,
    output logic [1:0] activeRefIndex,
    output timing_ref_pkg::quality_t nodeQuality,
    output logic holdInternal,
    output logic [1:0] supplyOutEnable,
    output logic [1:0] supplyOutAis,
    output logic [1:0] supplyOutB8zs,
    output timing_ref_pkg::source_t supplyOutSource
);
    localparam int RW = $clog2(REVERT_UNIT + 1);

    // map a raw S1 nibble to a rank in the chosen message set
    function automatic timing_ref_pkg::quality_t rank_of(input logic [3:0] s1,
            input logic g2, input timing_ref_pkg::quality_t resQ);
        timing_ref_pkg::quality_t q;
        q = g2 ? `G2_DUS : `G1_DUS;
        if (s1 == `S1_PRS) q = `Q_PRS;
        else if (s1 == `S1_STU) q = `Q_STU;
        else if (s1 == `S1_ST2) q = `Q_ST2;
        else if (s1 == `S1_TNC) q = g2 ? `G2_TNC : `G1_ST3;
        else if (s1 == `S1_ST3E) q = g2 ? `G2_ST3E : `G1_ST3;
        else if (s1 == `S1_ST3) q = g2 ? `G2_ST3 : `G1_ST3;
        else if (s1 == `S1_SMC) q = g2 ? `G2_SMC : `G1_SMC;
        else if (s1 == `S1_ST4) q = g2 ? `G2_ST4 : `G1_ST4;
        else if (s1 == `S1_RES) q = resQ;
        return q;
    endfunction

    function automatic timing_ref_pkg::quality_t dus_of(input logic g2);
        return g2 ? `G2_DUS : `G1_DUS;
    endfunction

    // sources allowed by the current mode
    function automatic logic allowed(input timing_ref_pkg::source_t s,
            input timing_ref_pkg::timing_mode_e m);
        logic a;
        a = 1'b0;
        if (s == `SRC_INTERNAL) a = 1'b1;
        else if (s == `SRC_SUPPLY1 || s == `SRC_SUPPLY2) a = (m != timing_ref_pkg::MODE_LINE);
        else if (s >= `SRC_LINE0 && s < 4'(`NUM_SRC)) a = (m != timing_ref_pkg::MODE_EXTERNAL);
        return a;
    endfunction

    // health from sampled link clocks; framing pins pass two flops inside, clock pins three
    logic [1:0] supplyGood;
    logic [5:0] lineGood;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sup
            link_edge_detect #(.TIMEOUT(LINK_TIMEOUT)) u_det (
                .refClk(ref_clk),
                .rstn(rstn),
                .linkClk(supplyClk[gi]),
                .linkOk(supplyFramed[gi]),
                .linkGood(supplyGood[gi])
            );
        end
        for (gi = 0; gi < `NUM_LINES; gi++) begin : g_line
            link_edge_detect #(.TIMEOUT(LINK_TIMEOUT)) u_det (
                .refClk(ref_clk),
                .rstn(rstn),
                .linkClk(lineClk[gi]),
                .linkOk(lineFramed[gi]),
                .linkGood(lineGood[gi])
            );
        end
    endgenerate

    // S1 values come from the framers on the same clock
    timing_ref_pkg::quality_t srcQ [`NUM_SRC];
    logic [`NUM_SRC-1:0] srcUsable;
    logic [1:0] supplyMsgOn;
    assign supplyMsgOn = supplySsmEn & supplyEsf;

    always_comb begin
        for (int i = 0; i < `NUM_SRC; i++) begin
            srcQ[i] = dus_of(gen2Set);
            srcUsable[i] = 1'b0;
        end
        srcQ[`SRC_INTERNAL] = gen2Set ? `G2_ST3 : `G1_ST3;
        srcUsable[`SRC_INTERNAL] = 1'b1;
        for (int i = 0; i < 2; i++) begin
            // without messaging the supply is taken at unknown traceability
            srcQ[1 + i] = supplyMsgOn[i] ? rank_of(supplySsm[i*4 +: 4], gen2Set,
                reservedQualitySetting) : `Q_STU;
            srcUsable[1 + i] = supplyInService[i] & supplyGood[i]
                & (srcQ[1 + i] != dus_of(gen2Set));
        end
        for (int i = 0; i < `NUM_LINES; i++) begin
            srcQ[`SRC_LINE0 + i] = rank_of(lineS1[i*4 +: 4], gen2Set,
                reservedQualitySetting);
            srcUsable[`SRC_LINE0 + i] = lineWorking[i] & lineGood[i]
                & (srcQ[`SRC_LINE0 + i] != dus_of(gen2Set));
        end
    end

    function automatic logic ok_src(input timing_ref_pkg::source_t s,
            input logic [`NUM_SRC-1:0] u, input timing_ref_pkg::timing_mode_e m);
        return (s < 4'(`NUM_SRC)) && (s != `SRC_NONE) && u[s] && allowed(s, m);
    endfunction

    wire ok1 = ok_src(nodeRef1, srcUsable, timingMode);
    wire ok2 = ok_src(nodeRef2, srcUsable, timingMode);
    wire ok3 = ok_src(nodeRef3, srcUsable, timingMode);
    // first healthy entry in priority order
    wire [1:0] bestIdx = ok1 ? 2'd0 : ok2 ? 2'd1 : ok3 ? 2'd2 : 2'd3;
    wire curOk = (activeRefIndex == 2'd0) ? ok1 : (activeRefIndex == 2'd1) ? ok2
        : (activeRefIndex == 2'd2) ? ok3 : 1'b0;

    // revert timer: counts units while a better reference is back
    logic [RW-1:0] unitCnt;
    logic [7:0] waitCnt;
    wire betterBack = (bestIdx < activeRefIndex) && (activeRefIndex != 2'd3);
    wire unitTick = (unitCnt == RW'(REVERT_UNIT - 1));
    wire waitDone = (waitCnt >= revertWaitUnits);

    logic [1:0] next_activeRefIndex;
    always_comb begin
        next_activeRefIndex = activeRefIndex;
        if (!curOk) begin
            next_activeRefIndex = bestIdx;
        end else if (betterBack && (!revertiveEn || waitDone)) begin
            // non-revertive stays on the working secondary
            next_activeRefIndex = revertiveEn ? bestIdx : activeRefIndex;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            unitCnt <= '0;
            waitCnt <= 8'h00;
        end else if (!(betterBack && curOk && revertiveEn)) begin
            unitCnt <= '0;
            waitCnt <= 8'h00;
        end else if (unitTick) begin
            unitCnt <= '0;
            waitCnt <= (waitCnt == 8'hff) ? waitCnt : waitCnt + 8'h01;
        end else begin
            unitCnt <= unitCnt + 1'b1;
        end
    end

    wire timing_ref_pkg::source_t selSrc = (next_activeRefIndex == 2'd0) ? nodeRef1
        : (next_activeRefIndex == 2'd1) ? nodeRef2
        : (next_activeRefIndex == 2'd2) ? nodeRef3 : `SRC_INTERNAL;
    wire timing_ref_pkg::quality_t selQ = srcQ[selSrc];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            activeRefIndex <= 2'd3;
            nodeSource <= `SRC_INTERNAL;
            nodeQuality <= `G1_ST3;
            holdInternal <= 1'b1;
        end else begin
            activeRefIndex <= next_activeRefIndex;
            nodeSource <= selSrc;
            nodeQuality <= selQ;
            holdInternal <= (selSrc == `SRC_INTERNAL);
        end
    end

    // output list: first usable of up to six entries
    logic [3:0] outPick;
    wire timing_ref_pkg::source_t outFirst = outRefList[3:0];
    always_comb begin
        outPick = `SRC_NONE;
        for (int i = 5; i >= 0; i--) begin
            if (ok_src(outRefList[i*4 +: 4], srcUsable, timing_ref_pkg::MODE_MIXED))
                outPick = outRefList[i*4 +: 4];
        end
    end

    // alarm signal when messaging is off and quality at or below floor
    wire [1:0] aisNeed;
    assign aisNeed[0] = ~supplyMsgOn[0] & (selQ >= alarmSignalQualityFloor);
    assign aisNeed[1] = ~supplyMsgOn[1] & (selQ >= alarmSignalQualityFloor);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            supplyOutEnable <= 2'b00;
            supplyOutAis <= 2'b00;
            supplyOutB8zs <= 2'b00;
            supplyOutSource <= `SRC_NONE;
        end else begin
            supplyOutEnable <= supplyInService;
            supplyOutAis <= aisNeed & supplyInService;
            supplyOutB8zs <= supplyB8zs;
            supplyOutSource <= outPick;
        end
    end

    // is for the operator; mixed mode is accepted as given

    a_isolated_internal: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!ok1 && !ok2 && !ok3) |=> (nodeSource == `SRC_INTERNAL) && holdInternal)
        else $error("isolated node not on internal");
    a_primary_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ok1 && activeRefIndex == 2'd0) |=> activeRefIndex == 2'd0)
        else $error("left healthy primary");
    a_fail_moves: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!curOk && ok2 && !ok1) |=> activeRefIndex == 2'd1)
        else $error("no failover to second");
    a_mode_respected: assert property (@(posedge ref_clk) disable iff (!rstn)
        (activeRefIndex != 2'd3 && curOk) |-> allowed(nodeSource, timingMode)
            || $changed(timingMode) || $changed(nodeRef1) || $changed(nodeRef2)
            || $changed(nodeRef3))
        else $error("source outside timing mode");
    a_no_early_revert: assert property (@(posedge ref_clk) disable iff (!rstn)
        (revertiveEn && curOk && betterBack && !waitDone && revertWaitUnits != 8'h00)
        |=> activeRefIndex == $past(activeRefIndex))
        else $error("revert before wait");
    a_nonrevert_stays: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!revertiveEn && curOk) |=> activeRefIndex == $past(activeRefIndex))
        else $error("non-revertive switched");
    a_out_follows_is: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> supplyOutEnable == $past(supplyInService))
        else $error("output enable lags service");
    a_ais_floor: assert property (@(posedge ref_clk) disable iff (!rstn)
        (supplyInService[0] && !supplyEsf[0] && selQ >= alarmSignalQualityFloor)
        |=> supplyOutAis[0])
        else $error("alarm signal missing in superframe");
    a_oos_silent: assert property (@(posedge ref_clk) disable iff (!rstn)
        (supplyInService != 2'b11)
        |=> ((supplyOutEnable | supplyOutAis) & ~$past(supplyInService)) == 2'b00)
        else $error("out of service output active");
    a_g1_map: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!gen2Set && supplyMsgOn[0] && supplySsm[3:0] == `S1_ST3E)
        |-> srcQ[`SRC_SUPPLY1] == `G1_ST3)
        else $error("newer code not mapped down");

    a_g2_st3e_rank: assert property (@(posedge ref_clk) disable iff (!rstn)
        (gen2Set && supplyMsgOn[0] && supplySsm[3:0] == `S1_ST3E)
        |-> srcQ[`SRC_SUPPLY1] == `G2_ST3E)
        else $error("newer code misranked");
    a_reserved_rank: assert property (@(posedge ref_clk) disable iff (!rstn)
        (supplyMsgOn[0] && supplySsm[3:0] == `S1_RES)
        |-> srcQ[`SRC_SUPPLY1] == reservedQualitySetting)
        else $error("reserved code not provisioned rank");
    a_msg_off_stu: assert property (@(posedge ref_clk) disable iff (!rstn)
        !supplySsmEn[0]
        |-> srcQ[`SRC_SUPPLY1] == `Q_STU)
        else $error("messaging off but code used");
    a_sf_no_msg: assert property (@(posedge ref_clk) disable iff (!rstn)
        !supplyEsf[1]
        |-> srcQ[`SRC_SUPPLY2] == `Q_STU)
        else $error("superframe but code used");
    a_internal_rank: assert property (@(posedge ref_clk) disable iff (!rstn)
        (selSrc == `SRC_INTERNAL)
        |=> nodeQuality == ($past(gen2Set) ? `G2_ST3 : `G1_ST3))
        else $error("internal rank wrong");
    a_never_dus: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> nodeQuality != ($past(gen2Set) ? `G2_DUS : `G1_DUS))
        else $error("do-not-use source selected");
    a_code_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> supplyOutB8zs == $past(supplyB8zs))
        else $error("line code not passed on");
    a_out_first: assert property (@(posedge ref_clk) disable iff (!rstn)
        ok_src(outFirst, srcUsable, timing_ref_pkg::MODE_MIXED)
        |=> supplyOutSource == $past(outFirst))
        else $error("output list skipped usable first");
    a_line_no_supply: assert property (@(posedge ref_clk) disable iff (!rstn)
        (timingMode == timing_ref_pkg::MODE_LINE)
        |-> (selSrc != `SRC_SUPPLY1) && (selSrc != `SRC_SUPPLY2))
        else $error("supply picked in line mode");
    a_ext_no_line: assert property (@(posedge ref_clk) disable iff (!rstn)
        (timingMode == timing_ref_pkg::MODE_EXTERNAL)
        |-> selSrc < `SRC_LINE0)
        else $error("line picked in external mode");
    a_revert_done: assert property (@(posedge ref_clk) disable iff (!rstn)
        (revertiveEn && curOk && betterBack && waitDone)
        |=> activeRefIndex == $past(bestIdx))
        else $error("no revert after wait");
    a_oos_unusable: assert property (@(posedge ref_clk) disable iff (!rstn)
        !supplyInService[0]
        |-> !srcUsable[`SRC_SUPPLY1])
        else $error("out of service supply usable");
    a_unframed_unusable: assert property (@(posedge ref_clk) disable iff (!rstn)
        !lineGood[0] |-> !srcUsable[`SRC_LINE0])
        else $error("failed line usable");
    a_ais_msg_on: assert property (@(posedge ref_clk) disable iff (!rstn)
        supplyMsgOn[1] |=> !supplyOutAis[1])
        else $error("alarm signal with messaging on");

    c_failover: cover property (@(posedge ref_clk) disable iff (!rstn)
        activeRefIndex == 2'd0 ##1 activeRefIndex == 2'd1);
    c_revert: cover property (@(posedge ref_clk) disable iff (!rstn)
        activeRefIndex == 2'd1 ##1 activeRefIndex == 2'd0);
    c_isolated: cover property (@(posedge ref_clk) disable iff (!rstn)
        activeRefIndex == 2'd3 && holdInternal);
    c_ais: cover property (@(posedge ref_clk) disable iff (!rstn) supplyOutAis != 2'b00);
    c_reserved: cover property (@(posedge ref_clk) disable iff (!rstn)
        supplyMsgOn[0] && supplySsm[3:0] == `S1_RES);
endmodule // timing_reference_selector
`default_nettype wire

// *** timing_source_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// far-side timing equipment: link clocks and framing per facility
module timing_source_model (
    input wire logic [1:0] supplyDead,
    input wire logic [5:0] lineDead,
    output logic [1:0] supplyClk,
    output logic [1:0] supplyFramed,
    output logic [5:0] lineClk,
    output logic [5:0] lineFramed
);
    logic linkPhase;
    // odd start offset keeps link edges off ref_clk edges, always 0.5 ns before a rising one
    initial begin
        linkPhase = 1'b0;
        #37;
        forever #100 linkPhase = ~linkPhase;
    end
    // a dead facility stands still low, so no stale edge hides the loss
    assign supplyClk = {2{linkPhase}} & ~supplyDead;
    assign lineClk = {6{linkPhase}} & ~lineDead;
    // framing drops with the signal, as on a real loss of signal
    assign supplyFramed = ~supplyDead;
    assign lineFramed = ~lineDead;
endmodule // timing_source_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "timing_ref_params.svh"
module tb;
    logic ref_clk, rstn, gen2Set, revertiveEn, holdInternal;
    timing_ref_pkg::timing_mode_e timingMode;
    timing_ref_pkg::quality_t reservedQualitySetting, alarmSignalQualityFloor, nodeQuality;
    timing_ref_pkg::source_t nodeRef1, nodeRef2, nodeRef3, nodeSource, supplyOutSource;
    logic [7:0] revertWaitUnits, supplySsm;
    logic [1:0] supplyInService, supplyB8zs, supplyEsf, supplySsmEn, supplyClk, supplyFramed;
    logic [1:0] supplyDead, activeRefIndex, supplyOutEnable, supplyOutAis, supplyOutB8zs;
    logic [23:0] outRefList, lineS1;
    logic [5:0] lineClk, lineFramed, lineWorking, lineDead;
    int error_cnt, total_checks;
    logic [3:0] s1Code [8] = '{`S1_PRS, `S1_STU, `S1_ST2, `S1_TNC, `S1_ST3E, `S1_ST3,
        `S1_SMC, `S1_ST4};
    // first set folds the newer codes down to the next level below
    logic [3:0] rankG1 [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h4, 4'h5, 4'h6};
    logic [3:0] rankG2 [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};

    timing_source_model timing_source_model_i (.supplyDead(supplyDead), .lineDead(lineDead),
        .supplyClk(supplyClk), .supplyFramed(supplyFramed), .lineClk(lineClk),
        .lineFramed(lineFramed));

    // short units keep revert waits to tens of cycles
    timing_reference_selector #(.LINK_TIMEOUT(16), .REVERT_UNIT(4)) timing_reference_selector_i (
        .ref_clk(ref_clk), .rstn(rstn), .timingMode(timingMode), .gen2Set(gen2Set),
        .reservedQualitySetting(reservedQualitySetting), .revertiveEn(revertiveEn),
        .revertWaitUnits(revertWaitUnits), .supplyInService(supplyInService),
        .supplyB8zs(supplyB8zs), .supplyEsf(supplyEsf), .supplySsmEn(supplySsmEn),
        .alarmSignalQualityFloor(alarmSignalQualityFloor), .nodeRef1(nodeRef1),
        .nodeRef2(nodeRef2), .nodeRef3(nodeRef3), .outRefList(outRefList),
        .supplyClk(supplyClk), .supplyFramed(supplyFramed), .supplySsm(supplySsm),
        .lineClk(lineClk), .lineFramed(lineFramed), .lineWorking(lineWorking),
        .lineS1(lineS1), .nodeSource(nodeSource), .activeRefIndex(activeRefIndex),
        .nodeQuality(nodeQuality), .holdInternal(holdInternal),
        .supplyOutEnable(supplyOutEnable), .supplyOutAis(supplyOutAis),
        .supplyOutB8zs(supplyOutB8zs), .supplyOutSource(supplyOutSource));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // outputs are compared on the falling edge, well clear of updates
    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic sel(input logic [1:0] idx, input logic [3:0] src, input int n);
        look(n);
        chk({2'b00, activeRefIndex}, {2'b00, idx});
        chk(nodeSource, src);
    endtask

    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end

    initial begin
        rstn = 1'b0; gen2Set = 1'b0; revertiveEn = 1'b1; revertWaitUnits = 8'h0a;
        timingMode = timing_ref_pkg::MODE_EXTERNAL; reservedQualitySetting = 4'h3;
        alarmSignalQualityFloor = 4'h2; supplyInService = 2'b11; supplyB8zs = 2'b01;
        supplyEsf = 2'b11; supplySsmEn = 2'b11; supplySsm = 8'h11; supplyDead = 2'b00;
        nodeRef1 = `SRC_SUPPLY1; nodeRef2 = `SRC_SUPPLY2; nodeRef3 = `SRC_INTERNAL;
        outRefList = 24'h000054; lineS1 = 24'h111111; lineWorking = 6'h3f; lineDead = 6'h00;
        error_cnt = 0; total_checks = 0;
        look(5);
        chk({2'b00, activeRefIndex}, 4'h3);
        chk(nodeSource, `SRC_INTERNAL);
        chk({2'b00, supplyOutEnable}, 4'h0);
        @(posedge ref_clk);
        rstn <= 1'b1;
        // starts on internal as the third reference, then reverts to the primary after the revert wait once its link is good
        sel(2'd0, `SRC_SUPPLY1, 60);
        chk({3'b000, holdInternal}, 4'h0);
        chk({2'b00, supplyOutEnable}, 4'h3);
        chk({2'b00, supplyOutB8zs}, 4'h1);
        chk({2'b00, supplyOutAis}, 4'h0);
        chk(supplyOutSource, `SRC_LINE0);
        for (int g = 0; g < 2; g++) begin
            for (int k = 0; k < 8; k++) begin
                @(posedge ref_clk);
                gen2Set <= g[0];
                supplySsm[3:0] <= s1Code[k];
                look(3);
                chk(nodeQuality, g ? rankG2[k] : rankG1[k]);
            end
        end
        @(posedge ref_clk);
        supplySsm[3:0] <= `S1_RES;
        look(3);
        chk(nodeQuality, 4'h3);
        @(posedge ref_clk);
        gen2Set <= 1'b0;
        supplySsm[3:0] <= `S1_DUS;
        sel(2'd1, `SRC_SUPPLY2, 4);
        @(posedge ref_clk);
        supplySsm[3:0] <= `S1_PRS;
        sel(2'd1, `SRC_SUPPLY2, 20);
        sel(2'd0, `SRC_SUPPLY1, 40);
        @(posedge ref_clk);
        supplyDead <= 2'b01;
        sel(2'd1, `SRC_SUPPLY2, 30);
        @(posedge ref_clk);
        supplyDead <= 2'b11;
        sel(2'd2, `SRC_INTERNAL, 30);
        chk(nodeQuality, `G1_ST3);
        chk({3'b000, holdInternal}, 4'h1);
        @(posedge ref_clk);
        nodeRef3 <= `SRC_NONE;
        sel(2'd3, `SRC_INTERNAL, 4);
        chk({3'b000, holdInternal}, 4'h1);
        @(posedge ref_clk);
        nodeRef3 <= `SRC_INTERNAL;
        @(posedge ref_clk);
        supplyDead <= 2'b00;
        sel(2'd0, `SRC_SUPPLY1, 80);
        @(posedge ref_clk);
        revertiveEn <= 1'b0;
        supplyDead <= 2'b01;
        sel(2'd1, `SRC_SUPPLY2, 30);
        @(posedge ref_clk);
        supplyDead <= 2'b00;
        sel(2'd1, `SRC_SUPPLY2, 80);
        @(posedge ref_clk);
        revertiveEn <= 1'b1;
        sel(2'd0, `SRC_SUPPLY1, 60);
        @(posedge ref_clk);
        timingMode <= timing_ref_pkg::MODE_LINE;
        sel(2'd2, `SRC_INTERNAL, 4);
        @(posedge ref_clk);
        nodeRef2 <= `SRC_LINE0;
        sel(2'd1, `SRC_LINE0, 60);
        // mixed only briefly, no loop can form with a one-node bench
        @(posedge ref_clk);
        timingMode <= timing_ref_pkg::MODE_MIXED;
        sel(2'd0, `SRC_SUPPLY1, 60);
        @(posedge ref_clk);
        timingMode <= timing_ref_pkg::MODE_EXTERNAL;
        nodeRef2 <= `SRC_SUPPLY2;
        supplyInService <= 2'b10;
        sel(2'd1, `SRC_SUPPLY2, 4);
        chk({2'b00, supplyOutEnable}, 4'h2);
        @(posedge ref_clk);
        supplyInService <= 2'b11;
        sel(2'd0, `SRC_SUPPLY1, 60);
        @(posedge ref_clk);
        supplySsmEn <= 2'b00;
        look(3);
        chk(nodeQuality, `Q_STU);
        chk({2'b00, supplyOutAis}, 4'h3);
        @(posedge ref_clk);
        alarmSignalQualityFloor <= 4'h3;
        look(3);
        chk({2'b00, supplyOutAis}, 4'h0);
        @(posedge ref_clk);
        alarmSignalQualityFloor <= 4'h2;
        supplySsmEn <= 2'b11;
        supplyEsf <= 2'b00;
        look(3);
        chk(nodeQuality, `Q_STU);
        chk({2'b00, supplyOutAis}, 4'h3);
        @(posedge ref_clk);
        supplyEsf <= 2'b11;
        lineDead <= 6'h01;
        look(30);
        chk(supplyOutSource, 4'h5);
        end_sim();
    end
endmodule // tb
`default_nettype wire
